// ---- inc/rxind_defs.svh ----
// constants for the receive indication and filter command block
`ifndef RXIND_DEFS_SVH
`define RXIND_DEFS_SVH
// indication type codes, bits 63..56
`define RXIND_TYPE_ERR_HI   3'h5
`define RXIND_TYPE_PERR     5'h19
`define RXIND_TYPE_SPLIT    8'h3a
`define RXIND_TYPE_OWN      8'h38
`define RXIND_TYPE_TOKEN    8'h3c
`define RXIND_TYPE_CAMRD    6'h3b
// command kinds, bits 61..56; the set-up code is a free choice
`define RXIND_CMD_SETUP     6'h2f
`define RXIND_CMD_READ      6'h3a
// receive status codes
`define RXIND_STT_NSA       3'h0
// port error codes
`define RXIND_PER_FIFO_ABT  4'hc
`define RXIND_PER_FIFO_PAR  4'hf
`define RXIND_PER_IDF_TABT  4'h4
`define RXIND_PER_IDF_FABT  4'h5
`define RXIND_PER_IDF_FPAR  4'h6
`define RXIND_PER_IDF_TPAR  4'h7
// field positions and table size
`define RXIND_IG_BIT        47
`define RXIND_VALID_BIT     55
`define RXIND_ENTRIES       32
`endif

// ---- inc/rxind_pkg.sv ----
// types shared by the receive indication block
package rxind_pkg;
	// frame status delivered by the mac
	typedef struct packed {
		logic [2:0] valid_flag_count;
		logic       error_indicator_flag;
		logic       address_recognized_flag;
		logic       frame_copied_flag;
		logic       extra_flag_one;
		logic       extra_flag_two;
	} rxind_fstat_t;

	// per-frame receive context
	typedef struct packed {
		logic         split;
		logic         first;
		rxind_fstat_t fstat;
		logic [12:0]  length;
	} rxind_frame_t;

	// port error sources
	typedef enum logic [2:0] {
		RXIND_PE_FIFO_ABT = 3'h0,
		RXIND_PE_FIFO_PAR = 3'h1,
		RXIND_PE_IDF_TABT = 3'h2,
		RXIND_PE_IDF_FABT = 3'h3,
		RXIND_PE_IDF_FPAR = 3'h4,
		RXIND_PE_IDF_TPAR = 3'h5
	} rxind_perr_t;

	// one indication bound for a ring
	typedef struct packed {
		logic        ring;
		logic [63:0] word;
	} rxind_ind_t;
endpackage

// ---- hw/rxind_skid.sv ----
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rxind_skid #(
	parameter int W = 65
) (
	input  wire logic         ref_clk,  // system clock
	input  wire logic         nrst,     // async reset, low
	input  wire logic         in_valid, // word offered
	output logic              in_ready, // room for a word
	input  wire logic [W-1:0] in_data,  // offered word
	output logic              out_valid,// word held
	input  wire logic         out_ready,// taker accepts
	output logic      [W-1:0] out_data  // held word
);
	logic [W-1:0] spare;
	logic         spare_full;

	// main and spare slots
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			out_valid  <= 1'b0;
			out_data   <= '0;
			spare      <= '0;
			spare_full <= 1'b0;
			in_ready   <= 1'b1;
		end
		else
		begin
			if (!out_valid || out_ready)
			begin
				if (spare_full)
				begin
					out_data   <= spare;
					out_valid  <= 1'b1;
					spare_full <= in_valid && in_ready;
					spare      <= in_data;
				end
				else
				begin
					out_data  <= in_data;
					out_valid <= in_valid && in_ready;
				end
				in_ready <= 1'b1;
			end
			else if (in_valid && in_ready)
			begin
				spare      <= in_data;
				spare_full <= 1'b1;
				in_ready   <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- hw/rxind_table.sv ----
// address filter table storage, registered read
`timescale 1ns/1ps
`default_nettype none
module rxind_table #(
	parameter int N = 32
) (
	input  wire logic                 ref_clk, // system clock
	input  wire logic                 nrst,    // async reset, low
	input  wire logic                 wr,      // write strobe
	input  wire logic [$clog2(N)-1:0] widx,    // write index
	input  wire logic [48:0]          wdata,   // valid and address
	input  wire logic [$clog2(N)-1:0] ridx,    // read index
	output logic      [48:0]          rdata    // valid and address
);
	logic [48:0] mem [N];

	// storage; valid bits clear at reset
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < N; i++)
				mem[i] <= '0;
			rdata <= '0;
		end
		else
		begin
			if (wr)
				mem[widx] <= wdata;
			rdata <= mem[ridx];
		end
	end
endmodule
`default_nettype wire

// ---- hw/rxind_core.sv ----
// receive indication builder and filter table command engine
`timescale 1ns/1ps
`default_nettype none
`include "rxind_defs.svh"
module rxind_core #(
	parameter int ENTRIES = `RXIND_ENTRIES,
	parameter int CNT_W   = 8
) (
	input  wire logic                   ref_clk,     // system clock 50 mhz
	input  wire logic                   nrst,        // async reset, low
	// per-frame context
	input  wire rxind_pkg::rxind_frame_t frame,      // split, first, status
	input  wire logic                   ring_sel,    // ring from frame ctl
	// receive error event
	input  wire logic                   err_ev,      // error indication due
	input  wire logic                   overrun,     // internal overrun
	input  wire logic                   rx_parity_flag,   // mac-side parity
	input  wire logic [2:0]             mac_rx_status,    // mac end data
	input  wire logic                   nsa_secondary,    // secondary nsa
	input  wire logic                   mac_interface_error, // event reg
	// port error event
	input  wire logic                   perr_ev,     // port failure
	input  wire rxind_pkg::rxind_perr_t perr_src,    // failure kind
	input  wire logic                   data_moved,  // some data moved
	// own frame event
	input  wire logic                   own_ev,      // own frame stripped
	input  wire logic                   own_frame_report_enable, // enable
	input  wire logic [1:0]             source_match_field, // match kind
	// token cycle
	input  wire logic                   token_end_report_enable, // enable
	input  wire logic                   tx_done,     // frame sent
	input  wire logic                   rx_back,     // own frame returned
	input  wire logic                   token_end,   // mac token end
	// filter command
	input  wire logic                   cmd_valid,   // command offered
	output logic                        cmd_ready,   // command taken
	input  wire logic [63:0]            cmd_word,    // command word
	input  wire logic                   cmd_ring,    // answer ring
	// indication output
	output logic                        ind_valid,   // indication held
	input  wire logic                   ind_ready,   // ring writer accepts
	output rxind_pkg::rxind_ind_t       ind,         // ring and word
	output logic                        busy         // event pending
);
	localparam int IW = $clog2(ENTRIES);

	// ------------------------------------------------------------
	// usage notes
	// ------------------------------------------------------------
	// one event becomes an indication per clock; events that meet in
	// one cycle keep only the highest by priority
	// events offered while the buffer is full are dropped, and busy rises a cycle
	// later, so the ring writer should keep ind_ready high wherever it can
	// the output register and the two buffer slots hold three
	// indications in all before busy rises
	// a read-entry answer holds the builder and masks every event
	// offered in the cycles it waits for room
	// the token counters clear on every token end, reported or not
	// frame, ring_sel and the status levels must stand with their
	// event strobe; nothing is captured ahead of it
	// set-up and read commands share the entry index in bits 52..48
	// the filter table leaves reset with every entry invalid
	// the split-data error indication carries its type code only

	// ------------------------------------------------------------
	// local signals
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RXIND_IDLE = 2'b00,
		RXIND_RD   = 2'b01,
		RXIND_RD2  = 2'b10
	} rxind_state_t;

	rxind_state_t          state;
	rxind_pkg::rxind_ind_t next_ind;
	logic                  next_push;
	logic                  buf_ready;
	logic                  out_load;  // output register takes a word
	logic                  buf_valid;
	rxind_pkg::rxind_ind_t buf_data;
	logic [CNT_W-1:0]      sent_cnt;
	logic [CNT_W-1:0]      lost_cnt;
	logic [IW-1:0]         rd_idx;
	logic                  rd_ring;
	logic [48:0]           tbl_rdata;
	logic                  tbl_wr;
	logic                  is_setup;
	logic                  is_read;
	logic [7:0]            fs_bits;
	logic [3:0]            per_code;
	logic                  token_fire;

	// ------------------------------------------------------------
	// field helpers
	// ------------------------------------------------------------
	// flags copied from mac frame status
	assign fs_bits = frame.fstat;
	// command decode: bit 63 marks a command, kind in bits 61..56
	// bit 55 carries the valid flag of a set-up, so it is not decoded
	assign is_setup = cmd_word[63] && cmd_word[61:56] == `RXIND_CMD_SETUP;
	assign is_read  = cmd_word[63] && cmd_word[61:56] == `RXIND_CMD_READ;
	assign tbl_wr   = cmd_valid && cmd_ready && is_setup;
	// buffer pops only when the output register really takes the word
	assign out_load = !ind_valid || ind_ready;
	assign token_fire = token_end && token_end_report_enable
		&& (sent_cnt != '0);

	// port error code selection
	always_comb
	begin
		unique case (perr_src)
			rxind_pkg::RXIND_PE_FIFO_ABT: per_code = `RXIND_PER_FIFO_ABT;
			rxind_pkg::RXIND_PE_FIFO_PAR: per_code = `RXIND_PER_FIFO_PAR;
			rxind_pkg::RXIND_PE_IDF_TABT: per_code = `RXIND_PER_IDF_TABT;
			rxind_pkg::RXIND_PE_IDF_FABT: per_code = `RXIND_PER_IDF_FABT;
			rxind_pkg::RXIND_PE_IDF_FPAR: per_code = `RXIND_PER_IDF_FPAR;
			rxind_pkg::RXIND_PE_IDF_TPAR: per_code = `RXIND_PER_IDF_TPAR;
			// codes 6 and 7 come from no legal source
			default:                      per_code = `RXIND_PER_FIFO_ABT;
		endcase
	end

	// ------------------------------------------------------------
	// indication builder, one event per cycle by priority
	// ------------------------------------------------------------
	always_comb
	begin
		next_ind  = '0;
		next_push = 1'b0;
		if (state == RXIND_RD2)
		begin
			// read-entry answer, first so that a slow ring
			// cannot starve it behind a stream of events
			next_push = 1'b1;
			next_ind.ring = rd_ring;
			next_ind.word[61:56] = `RXIND_TYPE_CAMRD;
			next_ind.word[`RXIND_VALID_BIT] = tbl_rdata[48];
			next_ind.word[52:48] = 5'(rd_idx);
			next_ind.word[47:0]  = tbl_rdata[47:0];
		end
		else if (err_ev || (perr_ev && frame.split && data_moved))
		begin
			// receive error, also for split data already moved
			next_push = 1'b1;
			next_ind.ring = ring_sel;
			next_ind.word[62] = frame.split;
			next_ind.word[61] = frame.first;
			next_ind.word[60:58] = `RXIND_TYPE_ERR_HI;
			next_ind.word[57] = overrun;
			next_ind.word[56] = rx_parity_flag;
			if (!mac_interface_error)
			begin
				next_ind.word[55:48] = fs_bits;
				next_ind.word[47:45] = nsa_secondary ? `RXIND_STT_NSA
					: mac_rx_status;
			end
			// else bits 55..48 stay zero
			next_ind.word[44:32] = frame.length;
		end
		else if (perr_ev && frame.split && !data_moved)
		begin
			// whole data portion discarded
			next_push = 1'b1;
			next_ind.ring = ring_sel;
			next_ind.word[63:56] = `RXIND_TYPE_SPLIT;
		end
		else if (perr_ev)
		begin
			next_push = 1'b1;
			next_ind.ring = ring_sel;
			next_ind.word[62] = frame.split;
			next_ind.word[61] = frame.first;
			next_ind.word[60:56] = `RXIND_TYPE_PERR;
			next_ind.word[55:48] = fs_bits;
			next_ind.word[35:32] = per_code;
		end
		else if (own_ev && own_frame_report_enable)
		begin
			next_push = 1'b1;
			next_ind.ring = ring_sel;
			next_ind.word[63:56] = `RXIND_TYPE_OWN;
			next_ind.word[55:48] = fs_bits;
			next_ind.word[47:46] = source_match_field;
		end
		else if (token_fire)
		begin
			next_push = 1'b1;
			next_ind.ring = ring_sel;
			next_ind.word[63:56] = `RXIND_TYPE_TOKEN;
			next_ind.word[32 +: CNT_W] = lost_cnt;
		end
	end

	// ------------------------------------------------------------
	// token cycle counters
	// ------------------------------------------------------------
	// sent_cnt: frames sent in the current token cycle
	// lost_cnt: frames sent and not yet back, floors at zero
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sent_cnt <= '0;
			lost_cnt <= '0;
		end
		else if (token_end)
		begin
			sent_cnt <= '0; // new cycle
			lost_cnt <= '0;
		end
		else
		begin
			if (tx_done)
				sent_cnt <= sent_cnt + CNT_W'(1);
			// sent minus returned
			if (tx_done && !rx_back)
				lost_cnt <= lost_cnt + CNT_W'(1);
			else if (rx_back && !tx_done && lost_cnt != '0)
				lost_cnt <= lost_cnt - CNT_W'(1);
		end
	end

	// ------------------------------------------------------------
	// command engine
	// ------------------------------------------------------------
	// cmd_ready toggles, so at most one command per two clocks;
	// a read keeps it low until the buffer has taken its answer
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state     <= RXIND_IDLE;
			rd_idx    <= '0;
			rd_ring   <= 1'b0;
			cmd_ready <= 1'b0;
		end
		else
		begin
			unique case (state)
				RXIND_IDLE:
				begin
					cmd_ready <= !cmd_ready && cmd_valid;
					if (cmd_valid && cmd_ready && is_read)
					begin
						rd_idx  <= cmd_word[48 +: IW];
						rd_ring <= cmd_ring;
						state   <= RXIND_RD;
						cmd_ready <= 1'b0;
					end
				end
				RXIND_RD:
					state <= RXIND_RD2;
				RXIND_RD2:
					if (buf_ready)
						state <= RXIND_IDLE;
				default:
					state <= RXIND_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// filter table, entry keeps bit 47 as individual/group
	// ------------------------------------------------------------
	rxind_table #(
		.N (ENTRIES)
	) rxind_table_i (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.wr      (tbl_wr),
		.widx    (cmd_word[48 +: IW]),
		.wdata   ({cmd_word[`RXIND_VALID_BIT], cmd_word[47:0]}),
		.ridx    (rd_idx),
		.rdata   (tbl_rdata)
	);

	// ------------------------------------------------------------
	// output buffer, stall reported through busy
	// ------------------------------------------------------------
	rxind_skid #(
		.W ($bits(rxind_pkg::rxind_ind_t))
	) rxind_skid_i (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (next_push),
		.in_ready  (buf_ready),
		.in_data   (next_ind),
		.out_valid (buf_valid),
		.out_ready (out_load),
		.out_data  (buf_data)
	);

	// registered outputs
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ind_valid <= 1'b0;
			ind       <= '0;
		end
		else if (out_load)
		begin
			ind_valid <= buf_valid;
			ind       <= buf_data;
		end
	end

	// busy: buffer full or a read answer pending
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			busy <= 1'b0;
		else
			busy <= !buf_ready || state != RXIND_IDLE;
	end
endmodule
`default_nettype wire

// ---- sim/rxind_core_sva.sv ----
// port assertions for the receive indication core
`timescale 1ns/1ps
`default_nettype none
module rxind_core_sva (
	input wire logic ref_clk, nrst, err_ev, overrun, rx_parity_flag,
	input wire logic nsa_secondary, mac_interface_error, perr_ev,
	input wire logic own_frame_report_enable, token_end_report_enable,
	input wire logic cmd_valid, cmd_ready, ind_valid, ind_ready, busy,
	input wire logic [2:0]              mac_rx_status, // mac end data
	input wire rxind_pkg::rxind_frame_t frame,         // frame context
	input wire rxind_pkg::rxind_perr_t  perr_src,      // failure kind
	input wire rxind_pkg::rxind_ind_t   ind            // ring and word
);
	localparam logic [3:0] pcode [6] = '{4'hc, 4'hf, 4'h4, 4'h5, 4'h6, 4'h7};
	logic idle; // nothing waiting at the output
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	assign idle = !busy && !ind_valid;
	// held word stays put while the ring stalls
	a_ind_holds: assert property (ind_valid && !ind_ready |=>
		ind_valid && $stable(ind)) else $error("indication moved in stall");
	// error indication built from the frame context
	a_err_head: assert property (
		err_ev && idle && !mac_interface_error |-> ##[1:5] ind_valid &&
		ind.word[63:48] == {1'h0, frame.split, frame.first, 3'h5, overrun,
		rx_parity_flag, frame.fstat}) else $error("error head wrong");
	a_err_stat: assert property (
		err_ev && idle && !mac_interface_error |-> ##[1:5] ind_valid &&
		ind.word[47:32] == {(nsa_secondary ? 3'h0 : mac_rx_status),
		frame.length}) else $error("error status or length wrong");
	a_mer_zero: assert property (
		err_ev && idle && mac_interface_error |-> ##[1:5] ind_valid &&
		ind.word[63:58] == {1'h0, frame.split, frame.first, 3'h5} &&
		ind.word[55:48] == 8'h00) else $error("flags not cleared");
	a_perr_code: assert property (
		perr_ev && idle && !frame.split |-> ##[1:5] ind_valid &&
		ind.word[63:56] == {1'h0, frame.split, frame.first, 5'h19} &&
		ind.word[35:32] == pcode[perr_src]) else $error("port code wrong");
	a_split_zero: assert property (
		ind_valid && ind.word[63:56] == 8'h3a |-> ind.word[55:32] == 24'h0)
		else $error("split data error not empty");
	a_own_gate: assert property (
		ind_valid && ind.word[63:56] == 8'h38 |-> own_frame_report_enable)
		else $error("own frame report while disabled");
	a_tok_gate: assert property (
		ind_valid && ind.word[63:56] == 8'h3c |-> token_end_report_enable)
		else $error("token report while disabled");
	a_cmd_gap: assert property (
		cmd_valid && cmd_ready |=> !cmd_ready) else $error("command gap");
	a_rst_quiet: assert property (disable iff (1'h0)
		!nrst |-> !ind_valid && !busy && !cmd_ready)
		else $error("outputs active in reset");
	// main scenarios reached
	c_err: cover property (err_ev && idle);
	c_stall: cover property (ind_valid && !ind_ready ##1 ind_valid);
	c_cmd: cover property (cmd_valid && cmd_ready);
endmodule
`default_nettype wire

// ---- sim/rxind_ring_model.sv ----
// ring writer model: takes indications, stalls when asked
`timescale 1ns/1ps
`default_nettype none
module rxind_ring_model (
	input  wire logic                  ref_clk,   // system clock
	input  wire logic                  nrst,      // async reset, low
	input  wire logic                  stall,     // bench asks for a stall
	input  wire logic                  ind_valid, // indication held
	input  wire rxind_pkg::rxind_ind_t ind,       // ring and word
	output logic                       ind_ready  // ring slot free
);
	rxind_pkg::rxind_ind_t q [$]; // words written to the rings
	// ready is a level, moved only just after an edge
	assign ind_ready = nrst && !stall;
	// one ring write per accepted word; split header status stays raw
	always @(posedge ref_clk)
	begin
		if (nrst && ind_valid && ind_ready)
			q.push_back(ind); // header status not interpreted
	end
endmodule
`default_nettype wire

// ---- sim/rxind_core_tb.sv ----
// self-checking bench for the receive indication core
`timescale 1ns/1ps
`default_nettype none
`include "rxind_defs.svh"
module rxind_core_tb;
	logic ref_clk, nrst, ring_sel, err_ev, overrun, rx_parity_flag, busy;
	logic nsa_secondary, mac_interface_error, perr_ev, data_moved, own_ev;
	logic own_frame_report_enable, token_end_report_enable, tx_done, stall;
	logic rx_back, token_end, cmd_valid, cmd_ready, cmd_ring, ind_valid;
	logic ind_ready, hold;
	logic [2:0] mac_rx_status;
	logic [1:0] source_match_field;
	logic [63:0] cmd_word;
	logic [31:0] seed;
	logic [47:0] addr [32];
	logic vld [32];
	rxind_pkg::rxind_frame_t frame;
	rxind_pkg::rxind_perr_t perr_src;
	rxind_pkg::rxind_ind_t ind;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	localparam logic [3:0] pcode [6] = '{4'hc, 4'hf, 4'h4, 4'h5, 4'h6, 4'h7};
	rxind_core rxind_core_i (.ref_clk, .nrst, .frame, .ring_sel, .err_ev,
		.overrun, .rx_parity_flag, .mac_rx_status, .nsa_secondary,
		.mac_interface_error, .perr_ev, .perr_src, .data_moved, .own_ev,
		.own_frame_report_enable, .source_match_field,
		.token_end_report_enable, .tx_done, .rx_back, .token_end,
		.cmd_valid, .cmd_ready, .cmd_word, .cmd_ring, .ind_valid,
		.ind_ready, .ind, .busy);
	rxind_ring_model rxind_ring_model_i (.ref_clk, .nrst, .stall,
		.ind_valid, .ind, .ind_ready);
	// clock
	initial
	begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ring stalls and hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		#1;
		stall = hold | ((cyc[3:0] ^ seed[3:0]) < 4'h5);
		if (cyc == 8000)
		begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic tick(input int n = 1);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	function automatic void roll();
		repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
	endfunction
	task automatic rand_in();
		roll();
		frame = seed[22:0];
		{ring_sel, overrun, rx_parity_flag} = seed[25:23];
	endtask
	task automatic pulse(ref logic ev);
		ev = 1'h1;
		tick();
		ev = 1'h0;
	endtask
	task automatic check(input logic [64:0] got, input logic [64:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// wait for one ring write and compare the masked word
	task automatic expect_ind(input logic rg, input logic [63:0] exp,
		input logic [63:0] msk);
		rxind_pkg::rxind_ind_t got;
		int n;
		n = 0;
		got = {~rg, ~exp};
		while (rxind_ring_model_i.q.size() == 0 && n < 40)
		begin
			tick();
			n++;
		end
		if (rxind_ring_model_i.q.size() != 0)
			got = rxind_ring_model_i.q.pop_front();
		check({got.ring, got.word & msk}, {rg, exp & msk});
	endtask
	task automatic expect_none();
		tick(12);
		check(65'(rxind_ring_model_i.q.size()), 65'h0);
	endtask
	// hold valid up; the caller drops it
	task automatic command(input logic [63:0] w);
		int n;
		n = 0;
		cmd_word = w;
		cmd_ring = seed[7];
		cmd_valid = 1'h1;
		while (cmd_ready !== 1'h1 && n < 20)
		begin
			tick();
			n++;
		end
		tick();
	endtask
	function automatic logic [63:0] err_word();
		return {1'h0, frame.split, frame.first, 3'h5, overrun, rx_parity_flag,
			mac_interface_error ? 8'h0 : frame.fstat,
			nsa_secondary ? 3'h0 : mac_rx_status, frame.length, 32'h0};
	endfunction
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// main sequence
	initial
	begin
		int k;
		int j;
		logic [4:0] idx;
		{ring_sel, err_ev, overrun, rx_parity_flag, nsa_secondary, hold,
			mac_interface_error, perr_ev, data_moved, own_ev, tx_done,
			own_frame_report_enable, token_end_report_enable, rx_back,
			token_end, cmd_valid, cmd_ring, mac_rx_status,
			source_match_field, cmd_word, frame} = '0;
		perr_src = rxind_pkg::RXIND_PE_FIFO_ABT;
		seed = 32'h08e2c518;
		nrst = 1'h0;
		tick(3);
		nrst = 1'h1;
		tick();
		for (int i = 1; i < 10; i++)
		begin
			rand_in();
			mac_rx_status = (i < 8) ? i[2:0] : (seed[28:26] | 3'h1);
			nsa_secondary = (i == 8);
			mac_interface_error = (i == 9);
			pulse(err_ev);
			expect_ind(ring_sel, err_word(), (i == 9) ?
				64'hffff_1fff_0000_0000 : 64'hffff_ffff_0000_0000);
		end
		mac_interface_error = 1'h0;
		$display("error indication test done");
		for (int i = 0; i < 8; i++)
		begin
			rand_in();
			frame.split = (i >= 6);
			data_moved = (i == 7);
			perr_src = rxind_pkg::rxind_perr_t'(i % 6);
			pulse(perr_ev);
			if (i < 6)
				expect_ind(ring_sel, {1'h0, frame.split, frame.first, 5'h19,
					frame.fstat, 12'h0, pcode[i], 32'h0}, 64'hffff_3fff_0000_0000);
			else if (i == 6)
				expect_ind(ring_sel, {8'h3a, 56'h0}, 64'hffff_ffff_0000_0000);
			else
				expect_ind(ring_sel, {2'h1, frame.first, 3'h5, 58'h0},
					64'hfc00_0000_0000_0000);
		end
		$display("port error test done");
		own_frame_report_enable = 1'h1;
		for (int i = 0; i < 4; i++)
		begin
			rand_in();
			source_match_field = i[1:0];
			pulse(own_ev);
			expect_ind(ring_sel, {8'h38, frame.fstat, source_match_field,
				46'h0}, 64'hffff_ffff_0000_0000);
		end
		own_frame_report_enable = 1'h0;
		pulse(own_ev);
		expect_none();
		$display("own frame test done");
		token_end_report_enable = 1'h1;
		for (int i = 0; i < 3; i++)
		begin
			rand_in();
			k = 1 + int'(seed[2:0]);
			j = (i == 0) ? k : int'(seed[5:3]) % k;
			for (int n = 0; n < 16; n++)
			begin
				tx_done = (n < k);
				rx_back = (n >= 8 && n < 8 + j);
				tick();
			end
			{tx_done, rx_back} = 2'h0;
			pulse(token_end);
			expect_ind(ring_sel, {8'h3c, 16'h0, 8'(k - j), 32'h0},
				64'hff00_00ff_0000_0000);
		end
		pulse(token_end);
		expect_none();
		token_end_report_enable = 1'h0;
		pulse(tx_done);
		pulse(token_end);
		expect_none();
		$display("token cycle test done");
		for (int i = 0; i < 32; i++)
		begin
			roll();
			addr[i] = {seed[15:0], seed ^ 32'h5a5a_0f0f};
			addr[i][47] = (i == 31) | addr[i][47];
			vld[i] = seed[20];
			command({2'h2, `RXIND_CMD_SETUP, vld[i], 2'h0,
				i[4:0], addr[i]});
		end
		for (int i = 0; i < 34; i++)
		begin
			roll();
			idx = (i < 32) ? 5'(31 - i) : seed[4:0];
			command({2'h2, `RXIND_CMD_READ, 3'h0, idx, seed[15:0], seed});
			cmd_valid = 1'h0;
			expect_ind(cmd_ring, {2'h0, `RXIND_TYPE_CAMRD, vld[idx],
				2'h0, idx, addr[idx]}, 64'hbf9f_ffff_ffff_ffff);
		end
		$display("filter table test done");
		hold = 1'h1;
		rand_in();
		for (int i = 0; i < 3; i++)
		begin
			pulse(err_ev);
			tick();
		end
		tick(3);
		check({64'h0, busy}, 65'h1);
		hold = 1'h0;
		expect_ind(ring_sel, err_word(), 64'hffff_ffff_0000_0000);
		expect_ind(ring_sel, err_word(), 64'hffff_ffff_0000_0000);
		expect_ind(ring_sel, err_word(), 64'hffff_ffff_0000_0000);
		expect_none();
		$display("buffer test done");
		print_verdict();
	end
endmodule
bind rxind_core rxind_core_sva rxind_core_sva_i (.ref_clk, .nrst, .err_ev,
	.overrun, .rx_parity_flag, .nsa_secondary, .mac_interface_error,
	.perr_ev, .own_frame_report_enable, .token_end_report_enable,
	.cmd_valid, .cmd_ready, .ind_valid, .ind_ready, .busy, .mac_rx_status,
	.frame, .perr_src, .ind);
`default_nettype wire
